// [hdl/csf_pkg.sv]
// ----------------------------------------------------------------
// shared constants of the synchronized merge forwarder
// ----------------------------------------------------------------
package csf_pkg;
	// register offsets
	localparam logic [7:0] A_GEN = 8'h02; // general_output_config
	localparam logic [7:0] A_FWD_MAP = 8'h20; // forward_port_map_control
	localparam logic [7:0] A_FWD_MODE = 8'h21; // forward_mode_control
	localparam logic [7:0] A_STATUS = 8'h23; // forward sync status
	localparam logic [7:0] A_PORT_SEL = 8'h32; // transmit_port_select
	localparam logic [7:0] A_TX_CTL = 8'h33; // transmitter_control
	localparam logic [7:0] A_DATA_ID = 8'h70; // per-port data identifier, 0x70..0x73
	// reset values
	localparam logic [7:0] RST_GEN = 8'h00;
	localparam logic [7:0] RST_FWD_MAP = 8'h0F;
	localparam logic [7:0] RST_FWD_MODE = 8'h00;
	localparam logic [7:0] RST_PORT_SEL = 8'h00;
	localparam logic [7:0] RST_TX_CTL = 8'h00;
	localparam logic [7:0] RST_DATA_ID = 8'h00;
	// field positions
	localparam int GEN_OEN_BIT = 0; // output_enable_bit
	localparam int GEN_OSS_BIT = 1; // output_sleep_state_select
	localparam int MAP_DIS_LSB = 0; // per_port_forward_disable [3:0]
	localparam int MAP_SEL_LSB = 4; // transmitter mapping [7:4]
	localparam int MODE_SYNC_LSB = 2; // synchronized_forward_select [5:2]
	localparam int TX_EN_BIT = 0;
	localparam int TX_CCLK_BIT = 1;
	localparam int TX_LANE_LSB = 4; // lane count code [5:4]
	localparam int PSEL_TX_BIT = 0;
	localparam int STAT_SYNC_BIT = 0;
	localparam int STAT_LOSS_BIT = 1;
	localparam int ID_VC_LSB = 6;
	// synchronized mode codes in [5:2]
	localparam logic [3:0] SYNC_BASIC = 4'h5;
	localparam logic [3:0] SYNC_ILV = 4'hA;
	localparam logic [3:0] SYNC_CAT = 4'hF;
	localparam logic [1:0] LANES_FOUR = 2'h0;
	localparam logic TX_INDEX = 1'b0; // mapping value of this transmitter
	// packet kinds at the receive buffers
	localparam logic [1:0] KIND_FS = 2'h0;
	localparam logic [1:0] KIND_FE = 2'h1;
	localparam logic [1:0] KIND_LINE = 2'h2;
	// data types of short packets
	localparam logic [5:0] DT_FS = 6'h00;
	localparam logic [5:0] DT_FE = 6'h01;
	// packet checksum and header code
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [5:0][23:0] ECC_MASK = {24'hEFFC00, 24'hDF03F0, 24'hB8E38E,
		24'h749A6D, 24'hF2555B, 24'hF12CB7};
	// engine states
	typedef enum logic [4:0] {
		ST_HUNT = 5'h01,
		ST_PICK = 5'h02,
		ST_HDR = 5'h04,
		ST_PAY = 5'h08,
		ST_CRC = 5'h10
	} csf_state_t;
endpackage : csf_pkg

// [hdl/csf_pair_buf.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// two-entry buffer between engine and transmitter
// ----------------------------------------------------------------
module csf_pair_buf #(
	parameter int W = 9
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_r [2]; // storage words
	logic wp_r; // write slot
	logic rp_r; // read slot
	logic [1:0] cnt_r; // words held
	logic wr_go;
	logic rd_go;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rp_r];
	assign wr_go = in_valid && in_ready;
	assign rd_go = out_valid && out_ready;

	// storage write
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else if (wr_go) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (wr_go) wp_r <= ~wp_r;
			if (rd_go) rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, wr_go} - {1'b0, rd_go};
		end
	end
endmodule : csf_pair_buf
`default_nettype wire

// [hdl/csf_forwarder.sv]
// Summary of operation
// - merged modes: one FS/FE, others dropped
// - interleave: each line own packet, port order
// - concatenate: same-index lines into one packet
// - concatenated header length and checksum rewritten
// - concatenate: channel of lowest forwarded port
// - concatenate bytewise, no padding between lines
// - sleep select zero: lanes drive HS-0
// - sleep select one, enable zero: hi-Z
// - power-down low: pins hi-Z always
// - both bits set: hi-Z idle, valid active
// - output active when mapped port locked
// - 0x14 in mode register: basic synchronized
// - 0x28 in mode register: line interleaving
// - 0x00 in port map clears disables
// - data id: channel top two, type low six
// - 0x01 in transmitter control: on, four lanes
// - port select gates transmitter register writes
// - sync loss: discard, resync at FS, flag
`timescale 1ns/100ps
`default_nettype none
module csf_forwarder (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic power_down_input,
	input wire logic [3:0] rx_lock,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] rx_valid,
	output logic [3:0] rx_ready,
	input wire logic [7:0] rx_kind,
	input wire logic [63:0] rx_wc,
	input wire logic [31:0] rx_data,
	input wire logic [3:0] rx_last,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic csi_lane_oe,
	output logic csi_hs_zero,
	output logic csi_tx_active,
	output logic tx_cont_clk,
	output logic [1:0] tx_lanes
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] low_port(input logic [3:0] m);
		low_port = 2'h0;
		for (int i = 3; i >= 0; i--) if (m[i]) low_port = 2'(i);
	endfunction : low_port

	function automatic logic [1:0] high_port(input logic [3:0] m);
		high_port = 2'h0;
		for (int i = 0; i < 4; i++) if (m[i]) high_port = 2'(i);
	endfunction : high_port

	function automatic logic [1:0] next_port(input logic [3:0] m, input logic [1:0] c);
		next_port = c;
		for (int i = 3; i >= 0; i--) if (m[i] && 2'(i) > c) next_port = 2'(i);
	endfunction : next_port

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		crc_byte = c;
		for (int i = 0; i < 8; i++) begin
			crc_byte = (crc_byte[0] ^ d[i]) ? ((crc_byte >> 1) ^ csf_pkg::CRC_POLY) : (crc_byte >> 1);
		end
	endfunction : crc_byte

	function automatic logic [7:0] hdr_ecc(input logic [23:0] h);
		hdr_ecc = 8'h00;
		for (int k = 0; k < 6; k++) hdr_ecc[k] = ^(h & csf_pkg::ECC_MASK[k]);
	endfunction : hdr_ecc

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic pd_s1, pd_s2; // power-down level
	logic [3:0] lock_s1, lock_s2; // receive lock levels

	// two stages before any use
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pd_s1 <= 1'b0;
			pd_s2 <= 1'b0;
			lock_s1 <= 4'h0;
			lock_s2 <= 4'h0;
		end else begin
			pd_s1 <= power_down_input;
			pd_s2 <= pd_s1;
			lock_s1 <= rx_lock;
			lock_s2 <= lock_s1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] gen_r, map_r, mode_r, psel_r, txc_r; // control registers
	logic [3:0][7:0] id_r; // per-port data identifiers
	logic synced_r; // engine in sync
	logic loss_r; // sticky sync loss
	logic [7:0] rd_mux;
	logic stat_rd; // status read strobe
	logic lose; // sync failure event

	// software writes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			gen_r <= csf_pkg::RST_GEN;
			map_r <= csf_pkg::RST_FWD_MAP;
			mode_r <= csf_pkg::RST_FWD_MODE;
			psel_r <= csf_pkg::RST_PORT_SEL;
			txc_r <= csf_pkg::RST_TX_CTL;
			id_r <= {4{csf_pkg::RST_DATA_ID}};
		end else if (reg_wr) begin
			case (reg_addr)
				csf_pkg::A_GEN: gen_r <= reg_wdata;
				csf_pkg::A_FWD_MAP: map_r <= reg_wdata;
				csf_pkg::A_FWD_MODE: mode_r <= reg_wdata;
				csf_pkg::A_PORT_SEL: psel_r <= reg_wdata;
				csf_pkg::A_TX_CTL: if (psel_r[csf_pkg::PSEL_TX_BIT]) txc_r <= reg_wdata;
				default: if (reg_addr[7:2] == csf_pkg::A_DATA_ID[7:2]) id_r[reg_addr[1:0]] <= reg_wdata;
			endcase
		end
	end

	// read data select
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr)
			csf_pkg::A_GEN: rd_mux = gen_r;
			csf_pkg::A_FWD_MAP: rd_mux = map_r;
			csf_pkg::A_FWD_MODE: rd_mux = mode_r;
			csf_pkg::A_STATUS: rd_mux = {6'h00, loss_r, synced_r};
			csf_pkg::A_PORT_SEL: rd_mux = psel_r;
			csf_pkg::A_TX_CTL: rd_mux = txc_r;
			default: if (reg_addr[7:2] == csf_pkg::A_DATA_ID[7:2]) rd_mux = id_r[reg_addr[1:0]];
		endcase
	end

	// registered read port
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) reg_rdata <= 8'h00;
		else if (reg_rd) reg_rdata <= rd_mux;
	end

	assign stat_rd = reg_rd && (reg_addr == csf_pkg::A_STATUS);

	// sticky loss: a new loss beats the read clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) loss_r <= 1'b0;
		else if (lose) loss_r <= 1'b1;
		else if (stat_rd) loss_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// forwarding set and mode decode
	// ----------------------------------------------------------------
	logic [3:0] fwd; // ports forwarded here
	logic [3:0] mapped; // ports mapped here
	logic [3:0] fs_head; // head is frame start
	logic [3:0] sync_mode;
	logic merged, concat, engine_on;
	logic [1:0] first_p, last_p;
	logic lock_any;
	logic [15:0] cat_wc; // joined line length

	for (genvar p = 0; p < 4; p++) begin : g_port
		assign mapped[p] = (map_r[csf_pkg::MAP_SEL_LSB + p] == csf_pkg::TX_INDEX);
		assign fwd[p] = mapped[p] && !map_r[csf_pkg::MAP_DIS_LSB + p];
		assign fs_head[p] = rx_valid[p] && (rx_kind[2*p +: 2] == csf_pkg::KIND_FS);
	end

	assign sync_mode = mode_r[csf_pkg::MODE_SYNC_LSB +: 4];
	assign merged = (sync_mode == csf_pkg::SYNC_ILV) || (sync_mode == csf_pkg::SYNC_CAT);
	assign concat = (sync_mode == csf_pkg::SYNC_CAT);
	assign engine_on = (merged || sync_mode == csf_pkg::SYNC_BASIC) && txc_r[csf_pkg::TX_EN_BIT] && (|fwd);
	assign first_p = low_port(fwd);
	assign last_p = high_port(fwd);
	assign lock_any = |(lock_s2 & mapped);

	// total length of the joined line
	always_comb begin
		cat_wc = 16'h0000;
		for (int p = 0; p < 4; p++) if (fwd[p]) cat_wc = cat_wc + rx_wc[16*p +: 16];
	end

	// ----------------------------------------------------------------
	// forwarding engine
	// ----------------------------------------------------------------
	csf_pkg::csf_state_t state_r;
	logic [1:0] cur_r; // port being served
	logic [1:0] kind_r; // round kind: FS, line or FE
	logic [1:0] bcnt_r; // byte within header or footer
	logic [31:0] hdr_r; // header bytes, first in low byte
	logic [15:0] crc_r; // running payload checksum
	logic hv, hl;
	logic [1:0] hk;
	logic [15:0] hwc;
	logic [7:0] hd;
	logic [1:0] id_p; // port giving channel and type
	logic [7:0] di;
	logic [15:0] wc;
	logic start, fe_turn, to_hdr, to_pay, adv, pay_end;
	logic push_v, buf_ready, b_valid, b_ready;
	logic [8:0] push_d, b_data;

	assign hv = rx_valid[cur_r];
	assign hl = rx_last[cur_r];
	assign hk = rx_kind[{cur_r, 1'b0} +: 2];
	assign hwc = rx_wc[{cur_r, 4'h0} +: 16];
	assign hd = rx_data[{cur_r, 3'h0} +: 8];
	assign id_p = concat ? first_p : cur_r;

	// header of the packet about to start
	always_comb begin
		di = {id_r[id_p][7:csf_pkg::ID_VC_LSB], id_r[id_p][5:0]};
		wc = concat ? cat_wc : hwc;
		if (kind_r == csf_pkg::KIND_FS) di[5:0] = csf_pkg::DT_FS;
		if (kind_r == csf_pkg::KIND_FE) di[5:0] = csf_pkg::DT_FE;
		if (kind_r != csf_pkg::KIND_LINE) wc = 16'h0000;
	end

	// handshakes and engine events
	always_comb begin
		rx_ready = 4'h0;
		push_v = 1'b0;
		push_d = 9'h000;
		start = 1'b0;
		fe_turn = 1'b0;
		to_hdr = 1'b0;
		to_pay = 1'b0;
		adv = 1'b0;
		pay_end = 1'b0;
		lose = 1'b0;
		case (state_r)
			csf_pkg::ST_HUNT: begin
				// discard everything but waiting frame starts
				rx_ready = rx_valid & ~(fs_head & fwd & {4{engine_on}});
				start = engine_on && (&(fs_head | ~fwd));
			end
			csf_pkg::ST_PICK: if (hv) begin
				if (kind_r == csf_pkg::KIND_LINE && hk == csf_pkg::KIND_FE && cur_r == first_p) fe_turn = 1'b1;
				else if (hk != kind_r) lose = 1'b1;
				else if (hk == csf_pkg::KIND_LINE) begin
					to_pay = concat && (cur_r != first_p);
					to_hdr = !to_pay;
				end else if (!merged || cur_r == first_p) to_hdr = 1'b1;
				else begin
					rx_ready[cur_r] = 1'b1;
					adv = 1'b1;
				end
			end
			csf_pkg::ST_HDR: begin
				push_v = 1'b1;
				push_d = {(bcnt_r == 2'h3) && (kind_r != csf_pkg::KIND_LINE), hdr_r[{bcnt_r, 3'h0} +: 8]};
				if (buf_ready && bcnt_r == 2'h3 && kind_r != csf_pkg::KIND_LINE) begin
					rx_ready[cur_r] = 1'b1;
					adv = 1'b1;
				end
			end
			csf_pkg::ST_PAY: begin
				push_v = hv;
				push_d = {1'b0, hd};
				rx_ready[cur_r] = buf_ready;
				pay_end = hv && buf_ready && hl;
				adv = pay_end && concat && (cur_r != last_p);
			end
			csf_pkg::ST_CRC: begin
				push_v = 1'b1;
				push_d = {bcnt_r[0], bcnt_r[0] ? crc_r[15:8] : crc_r[7:0]};
				adv = buf_ready && bcnt_r[0];
			end
			default: rx_ready = 4'h0;
		endcase
	end

	// engine state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= csf_pkg::ST_HUNT;
			cur_r <= 2'h0;
			kind_r <= csf_pkg::KIND_FS;
			bcnt_r <= 2'h0;
			hdr_r <= 32'h0000_0000;
		end else if (!engine_on || lose) begin
			state_r <= csf_pkg::ST_HUNT;
		end else begin
			case (state_r)
				csf_pkg::ST_HUNT: if (start) begin
					state_r <= csf_pkg::ST_PICK;
					cur_r <= first_p;
					kind_r <= csf_pkg::KIND_FS;
				end
				csf_pkg::ST_PICK: begin
					if (fe_turn) kind_r <= csf_pkg::KIND_FE;
					if (to_pay) state_r <= csf_pkg::ST_PAY;
					if (to_hdr) begin
						state_r <= csf_pkg::ST_HDR;
						bcnt_r <= 2'h0;
						hdr_r <= {hdr_ecc({wc, di}), wc, di};
					end
				end
				csf_pkg::ST_HDR: if (buf_ready) begin
					bcnt_r <= bcnt_r + 2'h1;
					if (bcnt_r == 2'h3 && kind_r == csf_pkg::KIND_LINE) state_r <= csf_pkg::ST_PAY;
				end
				csf_pkg::ST_PAY: if (pay_end && !adv) begin
					state_r <= csf_pkg::ST_CRC;
					bcnt_r <= 2'h0;
				end
				csf_pkg::ST_CRC: if (buf_ready) bcnt_r <= bcnt_r + 2'h1;
				default: state_r <= csf_pkg::ST_HUNT;
			endcase
			// step to the next forwarded port, or finish the round
			if (adv) begin
				state_r <= csf_pkg::ST_PICK;
				cur_r <= next_port(fwd, cur_r);
				if (cur_r == last_p) begin
					cur_r <= first_p;
					kind_r <= csf_pkg::KIND_LINE;
					if (kind_r == csf_pkg::KIND_FE) state_r <= csf_pkg::ST_HUNT;
				end
			end
		end
	end

	// payload checksum, restarted by each line header
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) crc_r <= csf_pkg::CRC_INIT;
		else if (to_hdr) crc_r <= csf_pkg::CRC_INIT;
		else if (state_r == csf_pkg::ST_PAY && hv && buf_ready) crc_r <= crc_byte(crc_r, hd);
	end

	// sync status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) synced_r <= 1'b0;
		else if (!engine_on || lose) synced_r <= 1'b0;
		else if (start) synced_r <= 1'b1;
	end

	// ----------------------------------------------------------------
	// output buffer and lane state
	// ----------------------------------------------------------------
	csf_pair_buf #(.W(9)) u_buf (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(push_v),
		.in_ready(buf_ready),
		.in_data(push_d),
		.out_valid(b_valid),
		.out_ready(b_ready),
		.out_data(b_data)
	);

	assign tx_valid = b_valid && csi_tx_active;
	assign b_ready = tx_ready && csi_tx_active;
	assign tx_data = b_data[7:0];
	assign tx_last = b_data[8];
	assign tx_cont_clk = txc_r[csf_pkg::TX_CCLK_BIT];
	assign tx_lanes = txc_r[csf_pkg::TX_LANE_LSB +: 2];

	// lane drive state from power, sleep select, enable, lock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			csi_lane_oe <= 1'b0;
			csi_hs_zero <= 1'b0;
			csi_tx_active <= 1'b0;
		end else if (!pd_s2) begin
			csi_lane_oe <= 1'b0;
			csi_hs_zero <= 1'b0;
			csi_tx_active <= 1'b0;
		end else if (!gen_r[csf_pkg::GEN_OSS_BIT]) begin
			csi_lane_oe <= 1'b1;
			csi_hs_zero <= 1'b1;
			csi_tx_active <= 1'b0;
		end else begin
			csi_lane_oe <= gen_r[csf_pkg::GEN_OEN_BIT] && lock_any;
			csi_hs_zero <= 1'b0;
			csi_tx_active <= gen_r[csf_pkg::GEN_OEN_BIT] && lock_any;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence seq_seam;
		state_r == csf_pkg::ST_PAY && pay_end && adv;
	endsequence
	sequence seq_line_end;
		state_r == csf_pkg::ST_PAY && pay_end && !adv;
	endsequence

	chk_pd_hiz: assert property (!pd_s2 |=> !csi_lane_oe && !csi_tx_active)
		else $error("lanes driven during power down");
	chk_sleep_hs0: assert property (pd_s2 && !gen_r[csf_pkg::GEN_OSS_BIT] |=> csi_lane_oe && csi_hs_zero)
		else $error("lanes not at HS-0");
	chk_oen_hiz: assert property (pd_s2 && gen_r[csf_pkg::GEN_OSS_BIT] && !gen_r[csf_pkg::GEN_OEN_BIT]
		|=> !csi_lane_oe)
		else $error("lanes driven with output disabled");
	chk_lock_valid: assert property (pd_s2 && (&gen_r[1:0]) |=> csi_tx_active == $past(lock_any))
		else $error("output state does not follow lock");
	chk_ports_open: assert property (reg_wr && reg_addr == csf_pkg::A_FWD_MAP && reg_wdata == 8'h00
		|=> fwd == 4'hF)
		else $error("ports not forwarded");
	chk_mode_basic: assert property (reg_wr && reg_addr == csf_pkg::A_FWD_MODE && reg_wdata == 8'h14
		|=> sync_mode == csf_pkg::SYNC_BASIC && !merged)
		else $error("basic mode not selected");
	chk_mode_ilv: assert property (reg_wr && reg_addr == csf_pkg::A_FWD_MODE && reg_wdata == 8'h28
		|=> merged && !concat)
		else $error("interleave not selected");
	chk_tx_enable: assert property (reg_wr && reg_addr == csf_pkg::A_TX_CTL && reg_wdata == 8'h01
		&& psel_r[0] |=> txc_r[0] && tx_lanes == csf_pkg::LANES_FOUR)
		else $error("transmitter not enabled");
	chk_port_sel: assert property (reg_wr && reg_addr == csf_pkg::A_TX_CTL && !psel_r[0] |=> $stable(txc_r))
		else $error("unselected transmitter written");
	chk_single_sync: assert property (state_r == csf_pkg::ST_HDR && kind_r != csf_pkg::KIND_LINE && merged
		|-> cur_r == first_p)
		else $error("extra frame sync packet");
	chk_cat_vc: assert property (state_r == csf_pkg::ST_HDR && bcnt_r == 2'h0 && concat
		|-> push_d[7:6] == id_r[first_p][7:6])
		else $error("wrong channel in joined packet");
	chk_data_id: assert property (state_r == csf_pkg::ST_HDR && bcnt_r == 2'h0 && kind_r == csf_pkg::KIND_LINE
		&& !concat |-> push_d[7:0] == id_r[cur_r])
		else $error("line header id mismatch");
	chk_cat_join: assert property (seq_seam |=> state_r == csf_pkg::ST_PICK && cur_r != first_p)
		else $error("joined line broken at seam");
	chk_crc_tail: assert property (seq_line_end |=> state_r == csf_pkg::ST_CRC && bcnt_r == 2'h0)
		else $error("footer missing after line");
	chk_loss_flag: assert property (lose |=> loss_r && !synced_r && state_r == csf_pkg::ST_HUNT)
		else $error("sync loss not flagged");
endmodule : csf_forwarder
`default_nettype wire

// [bench/csf_sink.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// downstream video receiver, optionally stalling
// ----------------------------------------------------------------
module csf_sink (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [8:0] got[$]; // received {last, byte}
	logic ph_r = 1'b0; // stall phase
	// store every accepted byte; the phase flips each cycle
	always @(posedge sys_clk) begin
		ph_r <= ~ph_r;
		if (tx_valid && tx_ready)
			got.push_back({tx_last, tx_data});
	end
	// when slow, refuse every other cycle
	assign tx_ready = !slow || ph_r;
endmodule : csf_sink
`default_nettype wire

// [bench/csf_forwarder_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench of the merge forwarder
// ----------------------------------------------------------------
module csi2_sync_merge_forwarder_bench;
	logic sys_clk = 1'b0, rstn = 1'b0, power_down_input = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
	logic [3:0] rx_lock = 4'h0, rx_valid, rx_ready, rx_last;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rx_kind, tx_data, rv;
	logic [63:0] rx_wc = 64'h0; // per-port line length
	logic [31:0] rx_data;
	logic tx_valid, tx_ready, tx_last, csi_lane_oe, csi_hs_zero, csi_tx_active, tx_cont_clk;
	logic [1:0] tx_lanes;
	logic [10:0] beat [4][8]; // {kind, last, byte}
	int nb [4] = '{0, 0, 0, 0};
	int ix [4] = '{0, 0, 0, 0};
	int miscompares = 0, n_checks = 0;
	initial forever #50 sys_clk = ~sys_clk;
	// receive buffer heads advance on each take
	for (genvar p = 0; p < 4; p++) begin : g_rx
		assign rx_valid[p] = ix[p] < nb[p];
		assign {rx_kind[2*p+1:2*p], rx_last[p], rx_data[8*p+7:8*p]} = beat[p][ix[p] % 8];
		always @(posedge sys_clk) if (rx_valid[p] && rx_ready[p]) ix[p] <= ix[p] + 1;
	end
	csf_forwarder DUT (.sys_clk(sys_clk), .rstn(rstn), .power_down_input(power_down_input),
		.rx_lock(rx_lock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_kind(rx_kind), .rx_wc(rx_wc), .rx_data(rx_data), .rx_last(rx_last),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
		.csi_lane_oe(csi_lane_oe), .csi_hs_zero(csi_hs_zero), .csi_tx_active(csi_tx_active),
		.tx_cont_clk(tx_cont_clk), .tx_lanes(tx_lanes));
	csf_sink SINK (.sys_clk(sys_clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rv = reg_rdata;
	endtask : rd
	// one frame of one line of n bytes on port p
	task automatic load(input int p, input int n);
		beat[p][0] = {csf_pkg::KIND_FS, 9'h000};
		for (int i = 0; i < n; i++) beat[p][i+1] = {csf_pkg::KIND_LINE, i == n - 1, 8'(16 * p + i)};
		beat[p][n+1] = {csf_pkg::KIND_FE, 9'h000};
		rx_wc[16*p+:16] = 16'(n);
		ix[p] = 0;
		nb[p] = n + 2;
	endtask : load
	task automatic wait_got(input int n);
		int k;
		for (k = 0; k < 3000 && SINK.got.size() < n; k++) @(posedge sys_clk);
		if (k == 3000) begin
			miscompares++;
			close_out();
		end
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(8'(SINK.got.size()), 8'(n));
	endtask : wait_got
	task automatic pins(input logic [2:0] e);
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({5'h0, csi_lane_oe, csi_hs_zero, csi_tx_active}, {5'h0, e});
	endtask : pins
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd(8'h20);
		chk(rv, 8'h0F);
		rd(8'h55);
		chk(rv, 8'h00);
		wr(8'h33, 8'h01);
		rd(8'h33);
		chk(rv, 8'h00);
		wr(8'h32, 8'h01);
		wr(8'h33, 8'h01);
		rd(8'h33);
		chk(rv, 8'h01);
		chk({6'h0, tx_lanes}, 8'h00);
		wr(8'h21, 8'h14);
		rd(8'h21);
		chk(rv, 8'h14);
	endtask : t_regs
	task automatic t_pins();
		pins(3'b110);
		@(posedge sys_clk);
		power_down_input <= 1'b0;
		pins(3'b000);
		@(posedge sys_clk);
		power_down_input <= 1'b1;
		wr(8'h02, 8'h02);
		pins(3'b000);
		wr(8'h02, 8'h03);
		pins(3'b000);
		@(posedge sys_clk);
		rx_lock <= 4'h4;
		pins(3'b101);
	endtask : t_pins
	task automatic t_ilv();
		for (int p = 0; p < 4; p++) wr(8'h70 + 8'(p), 8'h1F);
		wr(8'h21, 8'h28);
		wr(8'h20, 8'h00);
		@(negedge sys_clk);
		for (int p = 0; p < 4; p++) load(p, 2);
		wait_got(40);
		chk(SINK.got[0][7:0], 8'h00);
		for (int p = 0; p < 4; p++) begin
			chk(SINK.got[4+8*p][7:0], 8'h1F);
			chk(SINK.got[5+8*p][7:0], 8'h02);
			chk(SINK.got[9+8*p][7:0], 8'(16 * p + 1));
			chk({7'h0, SINK.got[11+8*p][8]}, 8'h01);
		end
		chk(SINK.got[36][7:0], 8'h01);
		rd(csf_pkg::A_STATUS);
		chk(rv, 8'h01);
	endtask : t_ilv
	task automatic t_cat();
		slow <= 1'b1;
		wr(8'h20, 8'h0F);
		wr(8'h21, 8'h3C);
		for (int p = 0; p < 4; p++) wr(8'h70 + 8'(p), 8'h1F + 8'(p) * 8'h40);
		wr(8'h20, 8'h01);
		@(negedge sys_clk);
		SINK.got.delete();
		for (int p = 0; p < 4; p++) load(p, 2);
		wait_got(20);
		chk(SINK.got[0][7:0], 8'h40);
		chk(SINK.got[4][7:0], 8'h5F);
		chk(SINK.got[5][7:0], 8'h06);
		for (int i = 0; i < 6; i++) chk(SINK.got[8+i][7:0], 8'(16 * (1 + i / 2) + i % 2));
		chk({7'h0, SINK.got[15][8]}, 8'h01);
		chk(SINK.got[16][7:0], 8'h41);
	endtask : t_cat
	// basic mode on ports 2 and 3: every stream keeps its own FS and FE
	task automatic t_basic();
		wr(8'h20, 8'h0F);
		wr(8'h21, 8'h14);
		wr(8'h20, 8'h03);
		@(negedge sys_clk);
		SINK.got.delete();
		load(2, 1);
		load(3, 1);
		wait_got(30);
		chk(SINK.got[0][7:0], 8'h80);
		chk(SINK.got[4][7:0], 8'hC0);
		chk(SINK.got[8][7:0], 8'h9F);
		chk(SINK.got[12][7:0], 8'h20);
		chk(SINK.got[15][7:0], 8'hDF);
		chk(SINK.got[22][7:0], 8'h81);
		chk(SINK.got[26][7:0], 8'hC1);
	endtask : t_basic
	// port 3 ends its frame early: loss flagged, cleared by the read
	task automatic t_loss();
		@(negedge sys_clk);
		load(2, 1);
		load(3, 0);
		repeat (200) @(posedge sys_clk);
		rd(csf_pkg::A_STATUS);
		chk(rv, 8'h02);
		rd(csf_pkg::A_STATUS);
		chk(rv, 8'h00);
		wr(8'h33, 8'h03);
		@(negedge sys_clk);
		chk({7'h0, tx_cont_clk}, 8'h01);
	endtask : t_loss
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_pins();
		t_ilv();
		t_cat();
		t_basic();
		t_loss();
		close_out();
	end
endmodule : csi2_sync_merge_forwarder_bench
`default_nettype wire
